// ### hdl/brpc_top.sv
// Local design decisions: the Wishbone register port and the register offsets.
module brpc_top #(
  parameter longint POR_CYCLES = brpc_pkg::POR_HOLD_CYCLES,
  parameter logic [31:0] SRESET_CFG_WORD = 32'h0000_0000
) (
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire logic [31:0] I_WB_ADR,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  input wire logic I_WB_WE,
  input wire logic [3:0] I_WB_SEL,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  output logic O_WB_ACK,
  input wire logic [4:0] I_STRAP_SWITCH_BANK,
  output logic [4:0] O_STRAP_PINS,
  output logic O_XCVR_ISOLATE_PIN,
  output logic O_XCVR_CFG_SEL0,
  output logic O_DUPLEX_PIN,
  output logic O_XCVR_CFG_SEL1,
  output logic O_XCVR_RESET_N,
  output logic O_MII_OUT_OE,
  output logic O_MII_DATA_CONNECT,
  output logic O_AUTONEG_RESTART,
  output logic O_SPEED_100,
  output logic O_FULL_DUPLEX,
  output logic O_LINKTEST_DIS,
  output logic O_ADV_100,
  output logic O_ADV_FULL_DUPLEX,
  input wire logic I_RAIL_SEL,
  input wire logic I_KEEP_ALIVE_RAIL_LOW,
  input wire logic I_MAIN_RAIL_LOW,
  output logic O_POWER_ON_RESET_IN_N,
  output logic O_BOARD_POR_N,
  input wire logic I_MAN_HRESET_N,
  input wire logic I_DBG_HRESET_N,
  input wire logic I_HRESET_I,
  output logic O_HRESET_O,
  output logic O_HRESET_OE,
  input wire logic I_DBG_SRESET_N,
  input wire logic I_MAN_SRESET_N,
  input wire logic I_SRESET_I,
  output logic O_SRESET_O,
  output logic O_SRESET_OE,
  output logic [31:0] O_SCFG_DATA,
  output logic O_SCFG_OE,
  input wire logic I_ABORT_BTN_N,
  input wire logic I_XCVR_INT_N,
  output logic O_NMI_N,
  output logic O_XCVR_INTERRUPT_LINE_N,
  input wire logic I_XCVR_SPEED_100,
  input wire logic I_XCVR_SCR_LOCK,
  input wire logic I_XCVR_IDLE_OK,
  input wire logic I_XCVR_LINK_10,
  output logic O_LED_SPEED,
  output logic O_LED_LINK,
  output logic O_LED_XCVR_ON
);

  localparam logic [31:0] POR_LOAD = POR_CYCLES[31:0];

  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [31:0] rd_data;
  logic ack_q;
  logic req;
  logic hit_ctrl;
  logic hit_stat;
  logic xcvr_enable_n;
  logic xcvr_cfg_sel0;
  logic xcvr_full_duplex_en;
  logic xcvr_cfg_sel1;
  logic xcvr_reset_n;
  logic autoneg_en;
  logic dte_mode;
  logic twisted_pair;
  logic cfg0_prev_q;
  logic restart_q;
  logic speed_q;
  logic duplex_q;
  logic linktest_dis_q;
  logic adv_100_q;
  logic adv_fd_q;
  logic rail_low;
  logic rail_low_prev_q;
  logic [31:0] por_cnt_q;
  logic por_active_q;
  logic main_por;
  logic hreset_drive;
  logic sreset_drive;
  logic nmi_n_q;
  logic xcvr_interrupt_line_n_q;
  logic led_speed_q;
  logic led_link_q;
  logic [31:0] scfg_q;
  logic scfg_oe_q;

  // Wishbone classic slave, one wait state
  assign req = I_WB_CYC && I_WB_STB;
  assign hit_ctrl = (I_WB_ADR[7:0] == brpc_pkg::CTRL_OFFSET)
    && (I_WB_ADR[31:8] == 24'h00_0000);
  assign hit_stat = (I_WB_ADR[7:0] == brpc_pkg::STAT_OFFSET)
    && (I_WB_ADR[31:8] == 24'h00_0000);

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  always_comb begin
    ctrl_d = ctrl_q;
    if (req && !ack_q && I_WB_WE && hit_ctrl) begin
      for (int b = 0; b < 4; b++) begin
        if (I_WB_SEL[b]) begin
          ctrl_d[8*b +: 8] = I_WB_DAT[8*b +: 8];
        end
      end
      // Unlisted bits stay zero; sharing the word needs RMW
      ctrl_d = ctrl_d & brpc_pkg::CTRL_WR_MASK;
    end
  end

  // Control bits power up with the transceiver disabled
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ctrl_q <= brpc_pkg::CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_data = ctrl_q;
    end else if (hit_stat) begin
      rd_data[brpc_pkg::STAT_STRAP_LSB +: brpc_pkg::STRAP_WIDTH] =
        I_STRAP_SWITCH_BANK;
      rd_data[brpc_pkg::STAT_POR_BIT] = por_active_q;
      rd_data[brpc_pkg::STAT_HRESET_BIT] = !I_HRESET_I;
      rd_data[brpc_pkg::STAT_SRESET_BIT] = !I_SRESET_I;
      rd_data[brpc_pkg::STAT_LED_SPEED_BIT] = led_speed_q;
      rd_data[brpc_pkg::STAT_LED_LINK_BIT] = led_link_q;
      rd_data[brpc_pkg::STAT_LED_XCVR_ON_BIT] = !xcvr_enable_n;
      rd_data[brpc_pkg::STAT_AUTONEG_BIT] = autoneg_en;
      rd_data[brpc_pkg::STAT_SPEED_SEL_BIT] = speed_q;
      rd_data[brpc_pkg::STAT_DUPLEX_BIT] = duplex_q;
      rd_data[brpc_pkg::STAT_LINKTEST_DIS_BIT] = linktest_dis_q;
      rd_data[brpc_pkg::STAT_ADV_100_BIT] = adv_100_q;
      rd_data[brpc_pkg::STAT_ADV_FD_BIT] = adv_fd_q;
    end
  end

  // Read data held in a flop so it is stable with ack
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_WB_DAT <= 32'h0000_0000;
    end else if (req && !ack_q && !I_WB_WE) begin
      O_WB_DAT <= rd_data;
    end
  end

  assign O_WB_ACK = ack_q;

  // Transceiver control pins
  assign xcvr_enable_n = ctrl_q[brpc_pkg::CTRL_ENABLE_N_BIT];
  assign xcvr_cfg_sel0 = ctrl_q[brpc_pkg::CTRL_CFG_SEL0_BIT];
  assign xcvr_full_duplex_en = ctrl_q[brpc_pkg::CTRL_FULL_DUPLEX_BIT];
  assign xcvr_cfg_sel1 = ctrl_q[brpc_pkg::CTRL_CFG_SEL1_BIT];
  assign xcvr_reset_n = ctrl_q[brpc_pkg::CTRL_RESET_N_BIT];

  assign O_XCVR_ISOLATE_PIN = xcvr_enable_n;
  assign O_XCVR_CFG_SEL0 = xcvr_cfg_sel0;
  assign O_DUPLEX_PIN = xcvr_full_duplex_en;
  assign O_XCVR_CFG_SEL1 = xcvr_cfg_sel1;
  assign O_XCVR_RESET_N = xcvr_reset_n;

  // Switch on drives the strap high; each bit means the ON function except STRAP_AUTONEG, where high turns autonegotiation off
  assign O_STRAP_PINS = I_STRAP_SWITCH_BANK;
  assign autoneg_en =
    !I_STRAP_SWITCH_BANK[brpc_pkg::STRAP_AUTONEG];
  assign dte_mode =
    I_STRAP_SWITCH_BANK[brpc_pkg::STRAP_STATION_MODE];
  assign twisted_pair =
    I_STRAP_SWITCH_BANK[brpc_pkg::STRAP_MEDIUM];

  // Either mode ends with the MII outputs undriven; DTE also cuts data
  assign O_MII_OUT_OE = !xcvr_enable_n;
  assign O_MII_DATA_CONNECT = !(xcvr_enable_n && dte_mode);

  // Autonegotiation restart and forced-mode settings
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cfg0_prev_q <= 1'b1;
      restart_q <= 1'b0;
    end else begin
      cfg0_prev_q <= xcvr_cfg_sel0;
      restart_q <= autoneg_en && xcvr_reset_n
        && xcvr_cfg_sel0 && !cfg0_prev_q;
    end
  end

  // Forced bits only follow the pins while autonegotiation is off
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      speed_q <= 1'b1;
      duplex_q <= 1'b1;
      linktest_dis_q <= 1'b1;
    end else if (!autoneg_en) begin
      speed_q <= xcvr_cfg_sel0;
      duplex_q <= xcvr_full_duplex_en;
      linktest_dis_q <= xcvr_cfg_sel1;
    end
  end

  // Fiber carries only 100 Mbps, so it always advertises 100
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      adv_100_q <= 1'b1;
      adv_fd_q <= 1'b1;
    end else if (autoneg_en) begin
      adv_100_q <= xcvr_cfg_sel1 || !twisted_pair;
      adv_fd_q <= xcvr_full_duplex_en
        && (xcvr_cfg_sel1 || !twisted_pair);
    end
  end

  assign O_AUTONEG_RESTART = restart_q;
  assign O_SPEED_100 = speed_q;
  assign O_FULL_DUPLEX = duplex_q;
  assign O_LINKTEST_DIS = linktest_dis_q;
  assign O_ADV_100 = adv_100_q;
  assign O_ADV_FULL_DUPLEX = adv_fd_q;

  // Power-on reset timer on the selected rail
  assign rail_low = (I_RAIL_SEL == brpc_pkg::RAIL_MAIN) ?
    I_MAIN_RAIL_LOW : I_KEEP_ALIVE_RAIL_LOW;

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rail_low_prev_q <= 1'b1;
    end else begin
      rail_low_prev_q <= rail_low;
    end
  end

  // Held while the rail sags, then a full period after it recovers
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      por_cnt_q <= POR_LOAD;
      por_active_q <= 1'b1;
    end else if (rail_low || rail_low_prev_q) begin
      por_cnt_q <= POR_LOAD;
      por_active_q <= 1'b1;
    end else if (por_cnt_q > 32'h0000_0001) begin
      por_cnt_q <= por_cnt_q - 32'h0000_0001;
    end else begin
      por_cnt_q <= 32'h0000_0000;
      por_active_q <= 1'b0;
    end
  end

  assign O_POWER_ON_RESET_IN_N = !por_active_q;
  assign main_por = por_active_q && (I_RAIL_SEL == brpc_pkg::RAIL_MAIN);
  assign O_BOARD_POR_N = !main_por;

  // Open-drain reset lines; the processor may pull them itself too
  assign hreset_drive = main_por || !I_MAN_HRESET_N
    || !I_DBG_HRESET_N;
  assign O_HRESET_O = 1'b0;
  assign O_HRESET_OE = hreset_drive;

  assign sreset_drive = !I_DBG_SRESET_N || !I_MAN_SRESET_N;
  assign O_SRESET_O = 1'b0;
  assign O_SRESET_OE = sreset_drive;

  // Line level covers processor-internal soft resets as well
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      scfg_q <= 32'h0000_0000;
      scfg_oe_q <= 1'b0;
    end else begin
      scfg_q <= SRESET_CFG_WORD;
      scfg_oe_q <= !I_SRESET_I;
    end
  end

  assign O_SCFG_DATA = scfg_q;
  assign O_SCFG_OE = scfg_oe_q;

  // Interrupt lines, retimed
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      nmi_n_q <= 1'b1;
      xcvr_interrupt_line_n_q <= 1'b1;
    end else begin
      nmi_n_q <= I_ABORT_BTN_N;
      xcvr_interrupt_line_n_q <= I_XCVR_INT_N;
    end
  end

  assign O_NMI_N = nmi_n_q;
  assign O_XCVR_INTERRUPT_LINE_N = xcvr_interrupt_line_n_q;

  // Indicators; dark while the transceiver is disabled
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      led_speed_q <= 1'b0;
      led_link_q <= 1'b0;
    end else begin
      led_speed_q <= !xcvr_enable_n && I_XCVR_SPEED_100;
      led_link_q <= !xcvr_enable_n && (I_XCVR_SPEED_100 ?
        (I_XCVR_SCR_LOCK && I_XCVR_IDLE_OK) : I_XCVR_LINK_10);
    end
  end

  assign O_LED_SPEED = led_speed_q;
  assign O_LED_LINK = led_link_q;
  assign O_LED_XCVR_ON = !xcvr_enable_n;

endmodule

// ### hdl/brpc_pkg.sv
package brpc_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STAT_OFFSET = 8'h04;

  // Control register fields
  localparam int CTRL_ENABLE_N_BIT = 4;
  localparam int CTRL_CFG_SEL0_BIT = 5;
  localparam int CTRL_FULL_DUPLEX_BIT = 6;
  localparam int CTRL_CFG_SEL1_BIT = 9;
  localparam int CTRL_RESET_N_BIT = 10;
  localparam logic [31:0] CTRL_WR_MASK = 32'h0000_0670;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0670;

  // Status register fields
  localparam int STAT_STRAP_LSB = 0;
  localparam int STAT_POR_BIT = 8;
  localparam int STAT_HRESET_BIT = 9;
  localparam int STAT_SRESET_BIT = 10;
  localparam int STAT_LED_SPEED_BIT = 11;
  localparam int STAT_LED_LINK_BIT = 12;
  localparam int STAT_LED_XCVR_ON_BIT = 13;
  localparam int STAT_AUTONEG_BIT = 14;
  localparam int STAT_SPEED_SEL_BIT = 15;
  localparam int STAT_DUPLEX_BIT = 16;
  localparam int STAT_LINKTEST_DIS_BIT = 17;
  localparam int STAT_ADV_100_BIT = 18;
  localparam int STAT_ADV_FD_BIT = 19;

  // Strap pin positions
  localparam int STRAP_AUTONEG = 0;
  localparam int STRAP_STATION_MODE = 1;
  localparam int STRAP_NIBBLE_SYMBOL = 2;
  localparam int STRAP_SCRAMBLER = 3;
  localparam int STRAP_MEDIUM = 4;
  localparam int STRAP_WIDTH = 5;

  // Timing
  localparam longint CLK_HZ = 10_000_000;
  localparam longint POR_HOLD_SEC = 4;
  localparam longint POR_HOLD_CYCLES = POR_HOLD_SEC * CLK_HZ;
  localparam int POR_CNT_WIDTH = 32;

  // Rail selection encoding
  localparam logic RAIL_KEEP_ALIVE = 1'b0;
  localparam logic RAIL_MAIN = 1'b1;
endpackage

// ### tb/brpc_top_assertions.sv
module brpc_top_assertions (
  input logic I_MCLK,
  input logic I_RST_N,
  input logic [4:0] I_STRAP_SWITCH_BANK,
  input logic [4:0] O_STRAP_PINS,
  input logic O_XCVR_ISOLATE_PIN,
  input logic O_MII_OUT_OE,
  input logic O_MII_DATA_CONNECT,
  input logic O_XCVR_CFG_SEL0,
  input logic O_XCVR_CFG_SEL1,
  input logic O_DUPLEX_PIN,
  input logic O_XCVR_RESET_N,
  input logic O_AUTONEG_RESTART,
  input logic O_SPEED_100,
  input logic O_FULL_DUPLEX,
  input logic O_ADV_100,
  input logic I_RAIL_SEL,
  input logic O_POWER_ON_RESET_IN_N,
  input logic O_BOARD_POR_N,
  input logic O_HRESET_OE,
  input logic I_MAN_HRESET_N,
  input logic I_DBG_HRESET_N,
  input logic I_ABORT_BTN_N,
  input logic O_NMI_N
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);
  AST_MII_OE: assert property (O_MII_OUT_OE == !O_XCVR_ISOLATE_PIN)
    else $error("mii output enable wrong");
  AST_DTE_ISO: assert property (O_MII_DATA_CONNECT ==
    !(O_XCVR_ISOLATE_PIN && I_STRAP_SWITCH_BANK[1]))
    else $error("dte isolation wrong");
  AST_STRAP: assert property (O_STRAP_PINS == I_STRAP_SWITCH_BANK)
    else $error("strap pins wrong");
  AST_RESTART: assert property ($rose(O_XCVR_CFG_SEL0) &&
    !I_STRAP_SWITCH_BANK[0] && O_XCVR_RESET_N |=> O_AUTONEG_RESTART)
    else $error("no autoneg restart");
  AST_SPEED: assert property (I_STRAP_SWITCH_BANK[0] &&
    $past(I_STRAP_SWITCH_BANK[0]) |-> O_SPEED_100 == $past(O_XCVR_CFG_SEL0))
    else $error("forced speed wrong");
  AST_DUPLEX: assert property (I_STRAP_SWITCH_BANK[0] &&
    $past(I_STRAP_SWITCH_BANK[0]) |-> O_FULL_DUPLEX == $past(O_DUPLEX_PIN))
    else $error("forced duplex wrong");
  AST_ADV_SPD: assert property (!I_STRAP_SWITCH_BANK[0] &&
    !$past(I_STRAP_SWITCH_BANK[0]) |-> O_ADV_100 ==
    $past(O_XCVR_CFG_SEL1 | !I_STRAP_SWITCH_BANK[4]))
    else $error("advertised speed wrong");
  AST_BOARD_POR: assert property (O_BOARD_POR_N ==
    !(!O_POWER_ON_RESET_IN_N && I_RAIL_SEL))
    else $error("board reset wrong");
  AST_HRST: assert property (O_HRESET_OE == (!O_BOARD_POR_N ||
    !I_MAN_HRESET_N || !I_DBG_HRESET_N))
    else $error("hard reset drive wrong");
  AST_NMI: assert property (O_NMI_N == $past(I_ABORT_BTN_N))
    else $error("abort not passed on");
endmodule

bind brpc_top brpc_top_assertions i_brpc_top_assertions (.*);

// ### tb/brpc_xcvr_model.sv
module brpc_xcvr_model (
  input wire logic i_reset_n,
  input wire logic i_speed_100,
  input wire logic i_link_up,
  output logic o_speed_100,
  output logic o_scr_lock,
  output logic o_idle_ok,
  output logic o_link_10
);
  timeunit 1ns;
  timeprecision 1ns;
  // Held in reset the part reports neither speed nor link
  assign o_speed_100 = i_reset_n & i_speed_100;
  assign o_scr_lock = i_reset_n & i_link_up;
  assign o_idle_ok = o_scr_lock & i_speed_100;
  assign o_link_10 = o_scr_lock & !i_speed_100;
endmodule

// ### tb/brpc_top_test.sv
module brpc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam longint PC = 20;
  localparam logic [31:0] SCW = 32'h0000_5A3C;
  localparam logic [31:0] HCW = 32'h0000_C3A5;
  logic I_MCLK, I_RST_N, I_WB_WE, I_WB_CYC, I_WB_STB, O_WB_ACK;
  logic [31:0] I_WB_ADR, I_WB_DAT, O_WB_DAT, O_SCFG_DATA, rd;
  logic [3:0] I_WB_SEL;
  logic [4:0] I_STRAP_SWITCH_BANK, O_STRAP_PINS;
  logic O_XCVR_ISOLATE_PIN, O_XCVR_CFG_SEL0, O_DUPLEX_PIN, O_XCVR_CFG_SEL1;
  logic O_XCVR_RESET_N, O_MII_OUT_OE, O_MII_DATA_CONNECT, O_AUTONEG_RESTART;
  logic O_SPEED_100, O_FULL_DUPLEX, O_LINKTEST_DIS, O_ADV_100;
  logic O_ADV_FULL_DUPLEX, I_RAIL_SEL, I_KEEP_ALIVE_RAIL_LOW, I_MAIN_RAIL_LOW;
  logic O_POWER_ON_RESET_IN_N, O_BOARD_POR_N, I_MAN_HRESET_N, I_DBG_HRESET_N;
  logic I_HRESET_I, O_HRESET_O, O_HRESET_OE, I_DBG_SRESET_N, I_MAN_SRESET_N;
  logic I_SRESET_I, O_SRESET_O, O_SRESET_OE, O_SCFG_OE, I_ABORT_BTN_N;
  logic I_XCVR_INT_N, O_NMI_N, O_XCVR_INTERRUPT_LINE_N, I_XCVR_SPEED_100;
  logic I_XCVR_SCR_LOCK, I_XCVR_IDLE_OK, I_XCVR_LINK_10, link_up;
  logic [31:0] hcfg_bus;
  logic O_LED_SPEED, O_LED_LINK, O_LED_XCVR_ON;
  int errors = 0, num_checks = 0, restarts = 0;
  brpc_top #(.POR_CYCLES(PC), .SRESET_CFG_WORD(SCW)) i_brpc_top (.*);
  brpc_xcvr_model i_brpc_xcvr_model (.i_reset_n(O_XCVR_RESET_N),
    .i_speed_100(O_SPEED_100), .i_link_up(link_up),
    .o_speed_100(I_XCVR_SPEED_100), .o_scr_lock(I_XCVR_SCR_LOCK),
    .o_idle_ok(I_XCVR_IDLE_OK), .o_link_10(I_XCVR_LINK_10));
  // Carrier side puts its hard-reset word on the bus while the line is low
  assign hcfg_bus = (I_HRESET_I && !O_HRESET_OE) ? 32'h0000_0000 : HCW;
  always @(posedge I_MCLK) if (O_AUTONEG_RESTART === 1'b1) restarts++;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("errors=%0d checks=%0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Request held until ack is sampled; one idle cycle follows
  task automatic wb(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge I_MCLK);
    {I_WB_ADR, I_WB_WE, I_WB_DAT, I_WB_SEL} <= {a, w, d, 4'hF};
    {I_WB_CYC, I_WB_STB} <= 2'b11;
    do begin
      @(posedge I_MCLK);
    end while (O_WB_ACK !== 1'b1);
    rd = O_WB_DAT;
    {I_WB_CYC, I_WB_STB, I_WB_WE} <= 3'b000;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge I_MCLK);
    #1;
  endtask
  task automatic t_regs();
    chk({O_MII_DATA_CONNECT, O_MII_OUT_OE}, 0);
    @(posedge I_MCLK) I_STRAP_SWITCH_BANK <= 5'h11;
    tick(1);
    chk({O_MII_DATA_CONNECT, O_MII_OUT_OE}, 2);
    chk(O_STRAP_PINS, 5'h11);
    @(posedge I_MCLK) I_STRAP_SWITCH_BANK <= 5'h13;
    wb(0, 0, 0);
    chk(rd, 32'h670);
    wb(0, 1, '1);
    wb(0, 0, 0);
    chk(rd, 32'h670);
    wb(8, 1, '1);
    wb(8, 0, 0);
    chk(rd, 0);
    wb(0, 1, 0);
    tick(2);
    chk({O_XCVR_ISOLATE_PIN, O_MII_OUT_OE, O_XCVR_RESET_N, O_LED_XCVR_ON},
      4'b0101);
  endtask
  task automatic t_forced();
    for (int i = 0; i < 8; i++) begin
      wb(0, 1, 32'h400 | {i[2], 2'b0, i[1], i[0], 5'b0});
      tick(3);
      chk(O_SPEED_100, i[0]);
      chk(O_FULL_DUPLEX, i[1]);
      chk(O_LINKTEST_DIS, i[2]);
      chk({O_XCVR_CFG_SEL1, O_DUPLEX_PIN, O_XCVR_CFG_SEL0}, i[2:0]);
      chk({O_LED_LINK, O_LED_SPEED}, {1'b1, i[0]});
    end
    chk(restarts, 0);
    @(posedge I_MCLK) link_up <= 1'b0;
    tick(3);
    chk(O_LED_LINK, 0);
    @(posedge I_MCLK) link_up <= 1'b1;
  endtask
  task automatic t_adv();
    logic a;
    logic [31:0] v;
    for (int i = 0; i < 8; i++) begin
      @(posedge I_MCLK) I_STRAP_SWITCH_BANK <= {i[2], 4'b0010};
      wb(0, 1, 32'h420 | {i[1], 2'b0, i[0], 6'b0});
      tick(3);
      a = i[1] | !i[2];
      chk({O_ADV_FULL_DUPLEX, O_ADV_100}, {i[0] & a, a});
    end
    wb(0, 0, 0);
    v = rd;
    chk(v, 32'h0000_0660);
    wb(0, 1, v & ~32'h0000_0020);
    wb(0, 1, v);
    wb(0, 1, v);
    tick(3);
    chk(restarts, 1);
  endtask
  task automatic t_por();
    @(posedge I_MCLK) I_MAIN_RAIL_LOW <= 1;
    tick(2);
    chk(O_POWER_ON_RESET_IN_N, 0);
    chk(O_BOARD_POR_N, 0);
    chk(O_HRESET_OE, 1);
    @(posedge I_MCLK) I_MAIN_RAIL_LOW <= 0;
    tick(PC - 2);
    chk(O_POWER_ON_RESET_IN_N, 0);
    tick(6);
    chk({O_POWER_ON_RESET_IN_N, O_HRESET_OE}, 2);
    @(posedge I_MCLK) {I_RAIL_SEL, I_KEEP_ALIVE_RAIL_LOW} <= 2'b01;
    tick(2);
    chk(O_POWER_ON_RESET_IN_N, 0);
    chk(O_BOARD_POR_N, 1);
    chk(O_HRESET_OE, 0);
    @(posedge I_MCLK) {I_RAIL_SEL, I_KEEP_ALIVE_RAIL_LOW} <= 2'b10;
    tick(PC + 6);
    chk(O_POWER_ON_RESET_IN_N, 1);
  endtask
  task automatic t_rst();
    for (int i = 0; i < 4; i++) begin
      @(posedge I_MCLK) {I_DBG_HRESET_N, I_MAN_HRESET_N} <= i[1:0];
      {I_DBG_SRESET_N, I_MAN_SRESET_N} <= i[1:0];
      tick(1);
      chk({O_HRESET_OE, O_SRESET_OE}, {2{i != 3}});
      chk({O_HRESET_O, O_SRESET_O}, 0);
      chk(hcfg_bus, (i != 3) ? HCW : 32'h0000_0000);
    end
    chk(O_SCFG_OE, 0);
    @(posedge I_MCLK) {I_HRESET_I, I_SRESET_I} <= 2'b00;
    tick(2);
    chk(O_SCFG_OE, 1);
    chk(O_SCFG_DATA, SCW);
    wb(4, 0, 0);
    chk(rd[10:9], 3);
    @(posedge I_MCLK) {I_HRESET_I, I_SRESET_I} <= 2'b11;
  endtask
  task automatic t_irq();
    @(posedge I_MCLK) {I_ABORT_BTN_N, I_XCVR_INT_N} <= 2'b00;
    tick(2);
    chk({O_NMI_N, O_XCVR_INTERRUPT_LINE_N}, 0);
    @(posedge I_MCLK) {I_ABORT_BTN_N, I_XCVR_INT_N} <= 2'b11;
    tick(2);
    chk({O_NMI_N, O_XCVR_INTERRUPT_LINE_N}, 3);
  endtask
  initial begin
    I_MCLK = 0;
    forever #50 I_MCLK = ~I_MCLK;
  end
  // Whole run is well under a thousand cycles
  initial begin
    #(5000 * 100);
    errors++;
    close_out();
  end
  initial begin
    {I_RST_N, I_WB_WE, I_WB_CYC, I_WB_STB, I_HRESET_I, I_SRESET_I} = 6'h03;
    {I_WB_ADR, I_WB_DAT, I_WB_SEL} = '0;
    {I_RAIL_SEL, I_KEEP_ALIVE_RAIL_LOW, I_MAIN_RAIL_LOW, link_up} = 4'b1001;
    {I_MAN_HRESET_N, I_DBG_HRESET_N, I_DBG_SRESET_N, I_MAN_SRESET_N} = '1;
    {I_ABORT_BTN_N, I_XCVR_INT_N} = '1;
    I_STRAP_SWITCH_BANK = 5'h13;
    repeat (20) @(posedge I_MCLK);
    I_RST_N <= 1;
    tick(PC + 6);
    t_regs();
    t_forced();
    t_adv();
    t_por();
    t_rst();
    t_irq();
    close_out();
  end
endmodule
